// ===== nltru_core.sv
// Nibble logic, bit test, compare-skip and rotate execution stage
// What this block does
// RULE1 - OR: each result bit is 1 when either operand bit is 1.
// RULE2 - AND: each result bit is 1 only when both operand bits are 1.
// RULE3 - XOR: each result bit is 1 only when the operand bits differ.
// RULE4 - Logic ops take register with memory, or memory with immediate.
// RULE5 - Logic ops ignore decimal and compare flags, keep carry and zero.
// RULE6 - Set-bit test skips when every masked memory bit is 1.
// RULE7 - Clear-bit test skips when every masked memory bit is 0.
// RULE8 - Bit tests read data memory only, never a general register.
// RULE9 - Either bit test clears the compare flag.
// RULE10 - Bit tests ignore decimal flag, keep carry and zero flags.
// RULE11 - With index enable set, bit-test memory address is index modified.
// RULE12 - Index modification ORs bank and address with the index register.
// RULE13 - Equal compare skips when memory nibble equals the immediate.
// RULE14 - Unequal compare skips when memory nibble differs from immediate.
// RULE15 - Greater-or-equal skips when memory is unsigned at least immediate.
// RULE16 - Less compare skips when memory is unsigned below immediate.
// RULE17 - Compares use memory against immediate only.
// RULE18 - Compares ignore decimal and compare flags, keep carry and zero.
// RULE19 - Right rotate operates on a general register only.
// RULE20 - Right rotate: old carry into bit 3, old bit 0 into carry.
// RULE21 - Right rotate changes only carry and the target register.
// RULE22 - Left rotate is add-with-carry of a value to itself.
// RULE23 - After a skip, the next instruction changes nothing.
`timescale 1ns/1ps
`default_nettype none
`include "nltru_regs.svh"

module nltru_core (
	input  wire logic                        clk,
	input  wire logic                        nrst,
	input  wire logic                        en,
	input  wire logic                        issue,
	input  wire nltru_pkg::nltru_op_t        op,
	input  wire nltru_pkg::nltru_form_t      form,
	input  wire logic [`NLTRU_NIB_W-1:0]     reg_data,
	input  wire logic [`NLTRU_NIB_W-1:0]     mem_data,
	input  wire logic [`NLTRU_NIB_W-1:0]     imm_data,
	input  wire logic [`NLTRU_BANK_W-1:0]    bank_in,
	input  wire logic [`NLTRU_ROW_W-1:0]     row_in,
	input  wire logic [`NLTRU_COL_W-1:0]     col_in,
	input  wire logic [`NLTRU_BANK_W-1:0]    ix_bank,
	input  wire logic [`NLTRU_ROW_W-1:0]     ix_row,
	input  wire logic [`NLTRU_COL_W-1:0]     ix_col,
	input  wire logic                        index_enable_flag,
	input  wire logic                        carry_flag,
	input  wire logic                        zero_flag,
	input  wire logic                        compare_only_flag,
	input  wire logic                        decimal_flag,
	output var logic [`NLTRU_BANK_W-1:0]     eff_bank_q,
	output var logic [`NLTRU_ROW_W-1:0]      eff_row_q,
	output var logic [`NLTRU_COL_W-1:0]      eff_col_q,
	output var logic [`NLTRU_NIB_W-1:0]      result_q,
	output var logic                         reg_we_q,
	output var logic                         mem_we_q,
	output var logic                         carry_q,
	output var logic                         zero_q,
	output var logic                         compare_q,
	output var logic                         flags_we_q,
	output var logic                         skip_q,
	output var logic                         suppressed_q
);
	import nltru_pkg::*;

	// Effective address: OR with index when index enable is set
	function automatic logic [`NLTRU_COL_W-1:0] ix_mod4(
		input logic [`NLTRU_COL_W-1:0] a,
		input logic [`NLTRU_COL_W-1:0] x,
		input logic                    ena
	);
		ix_mod4 = ena ? (a | x) : a; // see RULE12
	endfunction : ix_mod4

	function automatic logic is_skip_op(input nltru_op_t o);
		case (o)
			NLTRU_OP_BITS_SET, NLTRU_OP_BITS_CLEAR, NLTRU_OP_EQUAL,
			NLTRU_OP_NOT_EQUAL, NLTRU_OP_GREATER_EQUAL, NLTRU_OP_LESS: is_skip_op = 1'b1;
			default: is_skip_op = 1'b0;
		endcase
	endfunction : is_skip_op

	logic                     skip_pend_q;
	logic                     live;
	logic [`NLTRU_NIB_W-1:0]  res_d;
	logic                     rwe_d;
	logic                     mwe_d;
	logic                     carry_d;
	logic                     z_d;
	logic                     compare_d;
	logic                     fwe_d;
	logic                     skip_d;
	logic [`NLTRU_NIB_W-1:0]  opa;
	logic [`NLTRU_NIB_W-1:0]  opb;
	logic [`NLTRU_NIB_W:0]    sum;
	logic [`NLTRU_BANK_W-1:0] bank_d;
	logic [`NLTRU_ROW_W-1:0]  row_d;
	logic [`NLTRU_COL_W-1:0]  col_d;

	// A shadowed instruction is consumed without any effect
	assign live = issue && !skip_pend_q; // see RULE23

	// Bank and column are nibble wide; row is narrower
	assign bank_d = ix_mod4(bank_in, ix_bank, index_enable_flag); // see RULE11
	assign col_d  = ix_mod4(col_in, ix_col, index_enable_flag);   // see RULE11
	assign row_d  = index_enable_flag ? (row_in | ix_row) : row_in; // see RULE12

	// Register form pairs register with memory, else memory with immediate
	assign opa = (form == NLTRU_FORM_REG_MEM) ? reg_data : mem_data; // see RULE4
	assign opb = (form == NLTRU_FORM_REG_MEM) ? mem_data : imm_data; // see RULE4
	assign sum = {1'b0, opa} + {1'b0, opb} + {{`NLTRU_NIB_W{1'b0}}, carry_flag};

	always_comb begin
		res_d  = `NLTRU_NIB_RST;
		rwe_d  = 1'b0;
		mwe_d  = 1'b0;
		carry_d   = carry_flag;        // see RULE5, RULE18
		z_d       = zero_flag;         // see RULE5, RULE18
		compare_d = compare_only_flag;
		fwe_d     = 1'b0;              // see RULE5, RULE18
		skip_d = 1'b0;
		if (live) begin
			case (op)
				NLTRU_OP_OR: begin
					res_d = opa | opb; // see RULE1
					rwe_d = (form == NLTRU_FORM_REG_MEM);
					mwe_d = (form == NLTRU_FORM_MEM_IMM);
				end
				NLTRU_OP_AND: begin
					res_d = opa & opb; // see RULE2
					rwe_d = (form == NLTRU_FORM_REG_MEM);
					mwe_d = (form == NLTRU_FORM_MEM_IMM);
				end
				NLTRU_OP_XOR: begin
					res_d = opa ^ opb; // see RULE3
					rwe_d = (form == NLTRU_FORM_REG_MEM);
					mwe_d = (form == NLTRU_FORM_MEM_IMM);
				end
				NLTRU_OP_BITS_SET: begin
					// Memory only; register input never looked at
					skip_d    = ((mem_data & imm_data) == imm_data); // see RULE6, RULE8
					compare_d = 1'b0; // see RULE9
					fwe_d     = 1'b1; // see RULE10
				end
				NLTRU_OP_BITS_CLEAR: begin
					skip_d    = ((mem_data & imm_data) == `NLTRU_NIB_RST); // see RULE7, RULE8
					compare_d = 1'b0; // see RULE9
					fwe_d     = 1'b1;
				end
				NLTRU_OP_EQUAL:         skip_d = (mem_data == imm_data); // see RULE13, RULE17
				NLTRU_OP_NOT_EQUAL:     skip_d = (mem_data != imm_data); // see RULE14, RULE17
				NLTRU_OP_GREATER_EQUAL: skip_d = (mem_data >= imm_data); // see RULE15, RULE17
				NLTRU_OP_LESS:          skip_d = (mem_data < imm_data);  // see RULE16, RULE17
				NLTRU_OP_ROT_RIGHT: begin
					res_d   = {carry_flag, reg_data[`NLTRU_MSB:1]}; // see RULE19, RULE20
					carry_d = reg_data[`NLTRU_LSB];                 // see RULE20
					rwe_d = 1'b1;
					fwe_d = 1'b1; // see RULE21
				end
				NLTRU_OP_ADD_CARRY: begin
					// Feeding the same value on both sides rotates left
					res_d   = sum[`NLTRU_NIB_W-1:0]; // see RULE22
					carry_d = sum[`NLTRU_NIB_W];     // see RULE22
					z_d   = compare_only_flag ? (zero_flag && res_d == `NLTRU_NIB_RST)
						: (res_d == `NLTRU_NIB_RST);
					rwe_d = !compare_only_flag && (form == NLTRU_FORM_REG_MEM);
					mwe_d = !compare_only_flag && (form == NLTRU_FORM_MEM_IMM);
					fwe_d = 1'b1;
				end
				default: ;
			endcase
		end
	end

	// Skip shadow: one instruction issue after a taken skip
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			skip_pend_q <= 1'b0;
		end else if (en) begin
			if (issue) begin
				skip_pend_q <= skip_d; // see RULE23
			end
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			result_q     <= `NLTRU_NIB_RST;
			reg_we_q     <= 1'b0;
			mem_we_q     <= 1'b0;
			carry_q      <= 1'b0;
			zero_q       <= 1'b0;
			compare_q    <= 1'b0;
			flags_we_q   <= 1'b0;
			skip_q       <= 1'b0;
			suppressed_q <= 1'b0;
		end else if (en) begin
			result_q     <= res_d;
			reg_we_q     <= rwe_d;
			mem_we_q     <= mwe_d;
			carry_q      <= carry_d;
			zero_q       <= z_d;
			compare_q    <= compare_d;
			flags_we_q   <= fwe_d;
			skip_q       <= skip_d;
			suppressed_q <= issue && skip_pend_q;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			eff_bank_q <= `NLTRU_BANK_RST;
			eff_row_q  <= `NLTRU_ROW_RST;
			eff_col_q  <= `NLTRU_COL_RST;
		end else if (en) begin
			eff_bank_q <= bank_d;
			eff_row_q  <= row_d;
			eff_col_q  <= col_d;
		end
	end

	// Assertions
	or_result_a: assert property (@(posedge clk) disable iff (!nrst) // see RULE1
		en && live && op == NLTRU_OP_OR |=> result_q == ($past(opa) | $past(opb)))
		else $error("OR result wrong");

	and_result_a: assert property (@(posedge clk) disable iff (!nrst) // see RULE2
		en && live && op == NLTRU_OP_AND |=> result_q == ($past(opa) & $past(opb)))
		else $error("AND result wrong");

	xor_result_a: assert property (@(posedge clk) disable iff (!nrst) // see RULE3
		en && live && op == NLTRU_OP_XOR |=> result_q == ($past(opa) ^ $past(opb)))
		else $error("XOR result wrong");

	logic_dest_a: assert property (@(posedge clk) disable iff (!nrst) // see RULE4
		en && live && (op == NLTRU_OP_OR || op == NLTRU_OP_AND || op == NLTRU_OP_XOR)
		|=> (reg_we_q != mem_we_q) && !flags_we_q)
		else $error("Logic op destination or flags wrong");

	logic_flags_a: assert property (@(posedge clk) disable iff (!nrst) // see RULE5
		en && live && op == NLTRU_OP_XOR |=> !flags_we_q && !skip_q)
		else $error("Logic op touched flags");

	bits_set_a: assert property (@(posedge clk) disable iff (!nrst) // see RULE6
		en && live && op == NLTRU_OP_BITS_SET
		|=> skip_q == (($past(mem_data) & $past(imm_data)) == $past(imm_data)))
		else $error("Set-bit test skip wrong");

	bits_clear_a: assert property (@(posedge clk) disable iff (!nrst) // see RULE7
		en && live && op == NLTRU_OP_BITS_CLEAR
		|=> skip_q == (($past(mem_data) & $past(imm_data)) == `NLTRU_NIB_RST))
		else $error("Clear-bit test skip wrong");

	// Bit tests may never write a register or memory
	bit_no_write_a: assert property (@(posedge clk) disable iff (!nrst) // see RULE8
		en && live && (op == NLTRU_OP_BITS_SET || op == NLTRU_OP_BITS_CLEAR)
		|=> !reg_we_q && !mem_we_q)
		else $error("Bit test wrote data");

	bit_flag_clear_a: assert property (@(posedge clk) disable iff (!nrst) // see RULE9
		en && live && (op == NLTRU_OP_BITS_SET || op == NLTRU_OP_BITS_CLEAR)
		|=> flags_we_q && !compare_q && carry_q == $past(carry_flag)
		&& zero_q == $past(zero_flag))
		else $error("Bit test flag handling wrong");

	ix_addr_a: assert property (@(posedge clk) disable iff (!nrst) // see RULE12
		en && index_enable_flag |=> eff_col_q == ($past(col_in) | $past(ix_col))
		&& eff_bank_q == ($past(bank_in) | $past(ix_bank)))
		else $error("Index modification wrong");

	// Row is narrower than bank and column, so it gets its own check
	row_index_a: assert property (@(posedge clk) disable iff (!nrst) // see RULE11
		en && index_enable_flag |=> eff_row_q == ($past(row_in) | $past(ix_row)))
		else $error("Index row modification wrong");

	no_index_a: assert property (@(posedge clk) disable iff (!nrst) // see RULE11
		en && !index_enable_flag |=> eff_col_q == $past(col_in)
		&& eff_row_q == $past(row_in) && eff_bank_q == $past(bank_in))
		else $error("Address modified without index enable");

	equal_skip_a: assert property (@(posedge clk) disable iff (!nrst) // see RULE13
		en && live && op == NLTRU_OP_EQUAL |=> skip_q == ($past(mem_data) == $past(imm_data)))
		else $error("Equal skip wrong");

	unequal_skip_a: assert property (@(posedge clk) disable iff (!nrst) // see RULE14
		en && live && op == NLTRU_OP_NOT_EQUAL
		|=> skip_q == ($past(mem_data) != $past(imm_data)))
		else $error("Unequal skip wrong");

	skip_ge_a: assert property (@(posedge clk) disable iff (!nrst) // see RULE15
		en && live && op == NLTRU_OP_GREATER_EQUAL
		|=> skip_q == ($past(mem_data) >= $past(imm_data)) && !flags_we_q)
		else $error("Greater-or-equal skip wrong");

	skip_lt_a: assert property (@(posedge clk) disable iff (!nrst) // see RULE16
		en && live && op == NLTRU_OP_LESS |=> skip_q == ($past(mem_data) < $past(imm_data)))
		else $error("Less skip wrong");

	sequence compare_op_s;
		en && live && (op == NLTRU_OP_EQUAL || op == NLTRU_OP_NOT_EQUAL
		|| op == NLTRU_OP_GREATER_EQUAL || op == NLTRU_OP_LESS);
	endsequence

	// Compares only steer the sequencer; nothing is written
	compare_quiet_a: assert property (@(posedge clk) disable iff (!nrst) // see RULE18
		compare_op_s |=> !flags_we_q && !reg_we_q && !mem_we_q)
		else $error("Compare wrote state");

	rotate_right_a: assert property (@(posedge clk) disable iff (!nrst) // see RULE20
		en && live && op == NLTRU_OP_ROT_RIGHT
		|=> result_q == {$past(carry_flag), $past(reg_data[`NLTRU_MSB:1])}
		&& carry_q == $past(reg_data[`NLTRU_LSB]) && zero_q == $past(zero_flag) && reg_we_q)
		else $error("Right rotate wrong");

	rotate_only_a: assert property (@(posedge clk) disable iff (!nrst) // see RULE21
		en && live && op == NLTRU_OP_ROT_RIGHT
		|=> !mem_we_q && !skip_q && compare_q == $past(compare_only_flag))
		else $error("Right rotate touched more than carry and register");

	// Doubling plus old carry is the left rotate
	add_carry_a: assert property (@(posedge clk) disable iff (!nrst) // see RULE22
		en && live && op == NLTRU_OP_ADD_CARRY && form == NLTRU_FORM_REG_MEM
		&& reg_data == mem_data
		|=> {carry_q, result_q} == {$past(reg_data), $past(carry_flag)})
		else $error("Left rotate through add wrong");

	sequence skip_taken_s;
		en && issue && !skip_pend_q && is_skip_op(op) && skip_d;
	endsequence

	sequence shadow_quiet_s;
		!reg_we_q && !mem_we_q && !flags_we_q && !skip_q;
	endsequence

	skip_shadow_a: assert property (@(posedge clk) disable iff (!nrst) // see RULE23
		skip_taken_s ##1 (en && issue) |=> shadow_quiet_s and suppressed_q)
		else $error("Skipped instruction had an effect");
endmodule : nltru_core
`default_nettype wire

// ===== nltru_pkg.sv
// Types for the nibble logic, test and rotate unit
package nltru_pkg;
	typedef enum logic [3:0] {
		NLTRU_OP_NONE,
		NLTRU_OP_OR,
		NLTRU_OP_AND,
		NLTRU_OP_XOR,
		NLTRU_OP_BITS_SET,
		NLTRU_OP_BITS_CLEAR,
		NLTRU_OP_EQUAL,
		NLTRU_OP_NOT_EQUAL,
		NLTRU_OP_GREATER_EQUAL,
		NLTRU_OP_LESS,
		NLTRU_OP_ROT_RIGHT,
		NLTRU_OP_ADD_CARRY
	} nltru_op_t;
	typedef enum logic {
		NLTRU_FORM_REG_MEM,
		NLTRU_FORM_MEM_IMM
	} nltru_form_t;
endpackage : nltru_pkg

// ===== nltru_regs.svh
// Constants for the nibble logic, test and rotate unit
`ifndef NLTRU_REGS_SVH
`define NLTRU_REGS_SVH
`define NLTRU_NIB_W      4
`define NLTRU_BANK_W     4
`define NLTRU_ROW_W      3
`define NLTRU_COL_W      4
`define NLTRU_MSB        3
`define NLTRU_LSB        0
`define NLTRU_NIB_RST    4'h0
`define NLTRU_BANK_RST   4'h0
`define NLTRU_ROW_RST    3'h0
`define NLTRU_COL_RST    4'h0
`define NLTRU_OP_W       4
`endif

// ===== nltru_tb.sv
// Self-checking random bench for the nibble logic, test and rotate unit
`timescale 1ns/1ps
`default_nettype none
module tb;
	import nltru_pkg::*;
	logic        clk, nrst, en, issue, index_enable_flag, carry_flag, zero_flag;
	logic        compare_only_flag, decimal_flag, reg_we_q, mem_we_q, carry_q, zero_q;
	logic        compare_q, flags_we_q, skip_q, suppressed_q, sh;
	nltru_op_t   op;
	nltru_form_t form;
	logic [3:0]  reg_data, mem_data, imm_data, bank_in, col_in, ix_bank, ix_col;
	logic [3:0]  eff_bank_q, eff_col_q, result_q;
	logic [2:0]  row_in, ix_row, eff_row_q;
	logic [23:0] ex;
	logic [10:0] eex;
	integer      seed, n_fail, tests_run, cyc;

	nltru_core u_nltru_core (.clk(clk), .nrst(nrst), .en(en), .issue(issue), .op(op),
		.form(form), .reg_data(reg_data), .mem_data(mem_data), .imm_data(imm_data),
		.bank_in(bank_in), .row_in(row_in), .col_in(col_in), .ix_bank(ix_bank),
		.ix_row(ix_row), .ix_col(ix_col), .index_enable_flag(index_enable_flag),
		.carry_flag(carry_flag), .zero_flag(zero_flag), .compare_only_flag(compare_only_flag),
		.decimal_flag(decimal_flag), .eff_bank_q(eff_bank_q), .eff_row_q(eff_row_q),
		.eff_col_q(eff_col_q), .result_q(result_q), .reg_we_q(reg_we_q), .mem_we_q(mem_we_q),
		.carry_q(carry_q), .zero_q(zero_q), .compare_q(compare_q), .flags_we_q(flags_we_q),
		.skip_q(skip_q), .suppressed_q(suppressed_q));

	// Returns {care mask, expected}: result, reg_we, mem_we, flags_we, skip, supp, carry, zero, compare
	function automatic logic [23:0] model(nltru_op_t o, nltru_form_t f, logic [3:0] r, m, i,
		logic c, z, k, s);
		logic [11:0] e, w;
		logic [3:0]  a, b;
		logic [4:0]  sum;
		e = '0;
		w = 12'h0f8;
		a = (f == NLTRU_FORM_REG_MEM) ? r : m;
		b = (f == NLTRU_FORM_REG_MEM) ? m : i;
		sum = a + b + 5'(c);
		if (s)
			e[3] = 1'b1;
		else case (o)
			NLTRU_OP_OR, NLTRU_OP_AND, NLTRU_OP_XOR: begin
				e[11:8] = (o == NLTRU_OP_OR) ? a | b : (o == NLTRU_OP_AND) ? a & b : a ^ b;
				e[7] = (f == NLTRU_FORM_REG_MEM);
				e[6] = !e[7];
				w = 12'hff8;
			end
			NLTRU_OP_BITS_SET, NLTRU_OP_BITS_CLEAR: begin
				e[4] = (o == NLTRU_OP_BITS_SET) ? (m & i) == i : (m & i) == 4'h0;
				e[5] = 1'b1;
				e[2] = c;
				e[1] = z;
				w = 12'h0ff;
			end
			NLTRU_OP_EQUAL: e[4] = (m == i);
			NLTRU_OP_NOT_EQUAL: e[4] = (m != i);
			NLTRU_OP_GREATER_EQUAL: e[4] = (m >= i);
			NLTRU_OP_LESS: e[4] = (m < i);
			NLTRU_OP_ROT_RIGHT: begin
				e[11:8] = {c, r[3:1]};
				e[7] = 1'b1;
				e[5] = 1'b1;
				e[2] = r[0];
				e[1] = z;
				w = 12'hffe;
			end
			NLTRU_OP_ADD_CARRY: begin
				e[11:8] = sum[3:0];
				e[7] = !k && (f == NLTRU_FORM_REG_MEM);
				e[6] = !k && (f == NLTRU_FORM_MEM_IMM);
				e[5] = 1'b1;
				e[2] = sum[4];
				w = k ? 12'h0fc : 12'hffc;
			end
			default: ;
		endcase
		return {w, e & w};
	endfunction : model

	task automatic chk(input string what, input logic [11:0] got, exp);
		tests_run++;
		if (got !== exp) begin
			n_fail++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	// Drives one cycle just after an edge, checks the answer after the next edge
	task automatic step(input logic e, s, input nltru_op_t o, input nltru_form_t f,
		input logic [3:0] r, m, i, input logic c);
		{en, issue, reg_data, mem_data, imm_data, carry_flag, op, form} = {e, s, r, m, i, c, o, f};
		{zero_flag, compare_only_flag, decimal_flag, index_enable_flag, bank_in, row_in, col_in,
			ix_bank, ix_row, ix_col} = 26'($random(seed));
		@(posedge clk);
		#2;
		if (e) begin
			ex = s ? model(o, f, r, m, i, c, zero_flag, compare_only_flag, sh) : {12'h0f8, 12'h0};
			sh = s ? ex[4] : sh;
			eex = {bank_in, row_in, col_in} | ({11{index_enable_flag}} & {ix_bank, ix_row, ix_col});
		end
		chk("outputs", {result_q, reg_we_q, mem_we_q, flags_we_q, skip_q, suppressed_q, carry_q,
			zero_q, compare_q} & ex[23:12], ex[11:0]);
		chk("address", {1'b0, eff_bank_q, eff_row_q, eff_col_q}, {1'b0, eex});
		#3;
	endtask : step

	// Filler after each corner so a skip shadow never hides the next corner
	task automatic cc(input nltru_op_t o, input nltru_form_t f, input logic [3:0] r, m, i,
		input logic c);
		step(1'b1, 1'b1, o, f, r, m, i, c);
		step(1'b1, 1'b1, NLTRU_OP_XOR, NLTRU_FORM_MEM_IMM, r, m, i, c);
	endtask : cc

	task automatic end_sim;
		$display("checks %0d mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : end_sim

	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			n_fail++;
			end_sim;
		end
	end

	initial begin
		{seed, n_fail, tests_run, cyc, sh} = {32'h6be1, 32'h0, 32'h0, 32'h0, 1'b0};
		{nrst, en, issue, reg_data, mem_data, imm_data, carry_flag} = '0;
		{zero_flag, compare_only_flag, decimal_flag, index_enable_flag} = '0;
		{bank_in, row_in, col_in, ix_bank, ix_row, ix_col} = '0;
		op = NLTRU_OP_NONE;
		form = NLTRU_FORM_REG_MEM;
		ex = {12'hfff, 12'h0};
		eex = '0;
		repeat (6) @(posedge clk);
		#5;
		chk("reset", {result_q, reg_we_q, mem_we_q, flags_we_q, skip_q, suppressed_q}, 12'h0);
		nrst = 1'b1;
		cc(NLTRU_OP_OR, NLTRU_FORM_REG_MEM, 4'ha, 4'h9, 4'h0, 1'b0);
		cc(NLTRU_OP_OR, NLTRU_FORM_MEM_IMM, 4'ha, 4'h9, 4'hc, 1'b1);
		cc(NLTRU_OP_AND, NLTRU_FORM_REG_MEM, 4'ha, 4'h9, 4'h0, 1'b0);
		cc(NLTRU_OP_AND, NLTRU_FORM_MEM_IMM, 4'ha, 4'h9, 4'hc, 1'b1);
		cc(NLTRU_OP_BITS_SET, NLTRU_FORM_MEM_IMM, 4'h0, 4'hb, 4'hb, 1'b0);
		cc(NLTRU_OP_BITS_SET, NLTRU_FORM_REG_MEM, 4'hf, 4'hb, 4'hd, 1'b1);
		cc(NLTRU_OP_BITS_SET, NLTRU_FORM_MEM_IMM, 4'hf, 4'h0, 4'h0, 1'b0);
		cc(NLTRU_OP_BITS_CLEAR, NLTRU_FORM_MEM_IMM, 4'hf, 4'h9, 4'h6, 1'b1);
		cc(NLTRU_OP_BITS_CLEAR, NLTRU_FORM_MEM_IMM, 4'h0, 4'h9, 4'he, 1'b0);
		cc(NLTRU_OP_EQUAL, NLTRU_FORM_MEM_IMM, 4'h3, 4'ha, 4'ha, 1'b0);
		cc(NLTRU_OP_EQUAL, NLTRU_FORM_REG_MEM, 4'h8, 4'ha, 4'h8, 1'b0);
		cc(NLTRU_OP_NOT_EQUAL, NLTRU_FORM_MEM_IMM, 4'ha, 4'ha, 4'h8, 1'b1);
		cc(NLTRU_OP_NOT_EQUAL, NLTRU_FORM_MEM_IMM, 4'h0, 4'ha, 4'ha, 1'b1);
		for (int k = 7; k < 10; k++) begin
			cc(NLTRU_OP_GREATER_EQUAL, NLTRU_FORM_MEM_IMM, 4'h8, 4'h8, 4'(k), 1'b0);
			cc(NLTRU_OP_LESS, NLTRU_FORM_MEM_IMM, 4'h8, 4'h8, 4'(k), 1'b1);
		end
		cc(NLTRU_OP_GREATER_EQUAL, NLTRU_FORM_MEM_IMM, 4'h0, 4'h0, 4'hf, 1'b0);
		cc(NLTRU_OP_LESS, NLTRU_FORM_MEM_IMM, 4'h0, 4'hf, 4'hf, 1'b0);
		cc(NLTRU_OP_ROT_RIGHT, NLTRU_FORM_REG_MEM, 4'h8, 4'h3, 4'h0, 1'b1);
		cc(NLTRU_OP_ROT_RIGHT, NLTRU_FORM_REG_MEM, 4'h1, 4'h3, 4'h0, 1'b0);
		cc(NLTRU_OP_ADD_CARRY, NLTRU_FORM_REG_MEM, 4'h9, 4'h9, 4'h0, 1'b1);
		$display("corner cases done");
		repeat (3000)
			step({$random(seed)} % 8 != 0, {$random(seed)} % 5 != 0,
				nltru_op_t'(4'({$random(seed)} % 11 + 1)), nltru_form_t'(1'($random(seed))),
				4'($random(seed)), 4'($random(seed)), 4'($random(seed)), 1'($random(seed)));
		$display("random sequence done");
		end_sim;
	end
endmodule : tb
`default_nettype wire
